// File: src/cdd_top.sv
// top: code/data address decode and external bus selection
`timescale 1ns/1ps
`default_nettype none
module cdd_top
  import cdd_pkg::*;
#(
  parameter bit LARGE_PART = 1'b0
)(
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  // special-function register port
  input  wire logic             i_sfr_wr,
  input  wire logic [7:0]       i_sfr_addr,
  input  wire logic [7:0]       i_sfr_wdata,
  output logic      [7:0]       o_size_sel_rdata,
  // external-access pin, low means all code external
  input  wire logic             i_external_access_n,
  // code fetch request
  input  wire logic             i_fetch_req,
  input  wire logic [15:0]      i_fetch_addr,
  output logic                  o_fetch_stall,
  output cdd_route_t            o_fetch_route,
  // external data move request
  input  wire cdd_xreq_t        i_xreq,
  input  wire logic [1:0]       i_bank_sel,
  input  wire logic [7:0]       i_working_reg_byte,
  input  wire logic [7:0]       i_port_two_latch,
  input  wire logic [15:0]      i_data_pointer0,
  input  wire logic [15:0]      i_data_pointer1,
  input  wire logic             i_pointer_sel,
  output logic      [4:0]       o_working_reg_addr,
  output cdd_route_t            o_data_route,
  // page mode control
  input  wire logic             i_page_mode1,
  input  wire logic             i_page_hit,
  // scratchpad access classification
  input  wire logic [7:0]       i_scratch_addr,
  input  wire logic             i_scratch_indirect,
  output logic                  o_scratch_is_sfr,
  output logic                  o_scratch_is_upper,
  output logic                  o_scratch_bit_ok,
  // external bus pins
  output logic                  o_code_fetch_strobe_n,
  output logic                  o_rd_n,
  output logic                  o_wr_n,
  output logic      [7:0]       o_port_zero_addr,
  output logic      [7:0]       o_port_two_addr,
  output logic                  o_bus_owns_ports
);

  // ----------------------------------------------------------------
  // shared decode helpers
  // ----------------------------------------------------------------
  // inclusive address window, used for the code window and the bit window
  function automatic logic in_window(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // data moves past the on-chip sram leave the chip
  function automatic logic above_data_sram(input logic [15:0] a);
    return a > CDD_SRAM_DATA_MAX;
  endfunction

  // ----------------------------------------------------------------
  // size select register with timed access
  // ----------------------------------------------------------------
  // reset lands on the full flash size, so a fresh part runs all of its own code
  localparam logic [7:0] RST_VAL = LARGE_PART ? CDD_SIZE_SEL_RST_64K : CDD_SIZE_SEL_RST_16K;

  typedef enum logic [1:0] {
    TA_LOCKED,
    TA_KEY1_SEEN,
    TA_OPEN
  } cdd_ta_state_t;

  logic [7:0]    size_sel_q;
  logic [7:0]    size_sel_d;
  cdd_ta_state_t ta_state_q;
  cdd_ta_state_t ta_state_d;
  logic [2:0]    ta_cnt_q;
  logic [2:0]    ta_cnt_d;

  wire sel_hit     = i_sfr_wr && (i_sfr_addr == CDD_SIZE_SEL_ADDR);
  wire ta_hit      = i_sfr_wr && (i_sfr_addr == CDD_TA_ADDR);
  wire key1_hit    = ta_hit && (i_sfr_wdata == CDD_TA_KEY1);
  wire key2_hit    = ta_hit && (i_sfr_wdata == CDD_TA_KEY2);
  wire window_open = (ta_cnt_q != 3'h0);
  wire unlocked    = (ta_state_q == TA_OPEN) && window_open;
  wire size_take   = sel_hit && unlocked;

  // unlock opens only after both keys in order, and closes after a short window
  // a stray first key restarts the sequence, so a half-done unlock never lingers
  always_comb begin
    ta_state_d = ta_state_q;
    ta_cnt_d   = window_open ? ta_cnt_q - 3'h1 : 3'h0;
    if (key1_hit) begin
      ta_state_d = TA_KEY1_SEEN;
      ta_cnt_d   = CDD_TA_WINDOW;
    end else begin
      unique case (ta_state_q)
        TA_LOCKED: begin
          ta_state_d = TA_LOCKED;
        end
        TA_KEY1_SEEN: begin
          if (key2_hit && window_open) begin
            ta_state_d = TA_OPEN;
            ta_cnt_d   = CDD_TA_WINDOW;
          end else if (!window_open) begin
            ta_state_d = TA_LOCKED;
          end
        end
        TA_OPEN: begin
          if (size_take || !window_open) begin
            ta_state_d = TA_LOCKED;
          end
        end
        default: begin
          ta_state_d = TA_LOCKED;
        end
      endcase
    end
  end

  // the sram-as-code bit is open; only the limit bits are protected
  always_comb begin
    size_sel_d = size_sel_q;
    if (sel_hit) begin
      size_sel_d[CDD_SRAM_CODE_BIT] = i_sfr_wdata[CDD_SRAM_CODE_BIT];
    end
    if (size_take) begin
      size_sel_d[CDD_LIMIT_LSB +: CDD_LIMIT_W] = i_sfr_wdata[CDD_LIMIT_LSB +: CDD_LIMIT_W];
    end
    size_sel_d[7:4] = CDD_SIZE_SEL_UPPER[7:4];
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      size_sel_q <= RST_VAL;
    end else begin
      size_sel_q <= size_sel_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ta_state_q <= TA_LOCKED;
    end else begin
      ta_state_q <= ta_state_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ta_cnt_q <= 3'h0;
    end else begin
      ta_cnt_q <= ta_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // register readback
  // ----------------------------------------------------------------
  assign o_size_sel_rdata = size_sel_q;

  // ----------------------------------------------------------------
  // code fetch decode
  // ----------------------------------------------------------------
  logic [15:0] limit_max;
  logic        limit_none;

  // limit comes straight from the register, so a write steers the very next fetch
  cdd_limit_decode u_limit (
    .i_code     (size_sel_q[CDD_LIMIT_LSB +: CDD_LIMIT_W]),
    .o_max_addr (limit_max),
    .o_none     (limit_none)
  );

  wire sram_code_en = size_sel_q[CDD_SRAM_CODE_BIT];
  wire pin_ok       = i_external_access_n;
  // flash starts at zero and is contiguous to the limit; vectors live in its low bytes
  wire in_flash     = !limit_none && (i_fetch_addr <= limit_max);
  wire is_vector    = (i_fetch_addr <= CDD_VECTOR_MAX) && !limit_none;
  wire in_sram_code = sram_code_en && in_window(i_fetch_addr, CDD_SRAM_CODE_LO, CDD_SRAM_CODE_HI);
  wire fetch_int    = pin_ok && (in_flash || is_vector || in_sram_code);
  wire fetch_ext    = i_fetch_req && !fetch_int;

  // sram answers only where flash does not already cover the window
  wire      src_sram = in_sram_code && !in_flash;
  cdd_src_t fetch_src;
  assign fetch_src = !fetch_int ? CDD_SRC_EXT : (src_sram ? CDD_SRC_SRAM : CDD_SRC_FLASH);

  // ----------------------------------------------------------------
  // external data move decode
  // ----------------------------------------------------------------
  // working register address: bank from status register, register index low
  assign o_working_reg_addr = {i_bank_sel, i_xreq.reg_sel};

  wire [15:0] ptr_sel   = i_pointer_sel ? i_data_pointer1 : i_data_pointer0;
  wire [15:0] ri_addr   = {i_port_two_latch, i_working_reg_byte};
  wire [15:0] xaddr     = i_xreq.use_ptr ? ptr_sel : ri_addr;
  wire        xdata_ext = i_xreq.valid && above_data_sram(xaddr);

  // ----------------------------------------------------------------
  // external bus sequencing
  // ----------------------------------------------------------------
  // non-page cycle is four clocks; page mode 1 hits run without a stall
  logic [1:0] bus_cnt_q;
  logic [1:0] bus_cnt_d;
  logic       bus_code_q;
  logic       bus_code_d;
  logic       bus_wr_q;
  logic       bus_wr_d;
  logic [15:0] bus_addr_q;
  logic [15:0] bus_addr_d;
  logic       bus_act_q;
  logic       bus_act_d;

  wire bus_busy   = (bus_cnt_q != 2'h0);
  wire need_stall = !(i_page_mode1 && i_page_hit);
  wire start_code = fetch_ext && !bus_busy;
  // a tie goes to the fetch, since the core is already waiting on it
  wire start_data = xdata_ext && !bus_busy && !fetch_ext;
  wire bus_start  = start_code || start_data;

  always_comb begin
    bus_cnt_d  = bus_busy ? bus_cnt_q - 2'h1 : 2'h0;
    bus_code_d = bus_code_q;
    bus_wr_d   = bus_wr_q;
    bus_addr_d = bus_addr_q;
    // the strobe covers the last counted clock too, so a cycle spans four clocks
    bus_act_d  = bus_busy;
    if (bus_start) begin
      bus_cnt_d  = need_stall ? CDD_NONPAGE_STALLS : 2'h0;
      bus_code_d = start_code;
      bus_wr_d   = start_data && i_xreq.write;
      bus_addr_d = start_code ? i_fetch_addr : xaddr;
      bus_act_d  = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_cnt_q <= 2'h0;
    end else begin
      bus_cnt_q <= bus_cnt_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_code_q <= 1'b0;
    end else begin
      bus_code_q <= bus_code_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_wr_q <= 1'b0;
    end else begin
      bus_wr_q <= bus_wr_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_addr_q <= 16'h0000;
    end else begin
      bus_addr_q <= bus_addr_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_act_q <= 1'b0;
    end else begin
      bus_act_q <= bus_act_d;
    end
  end

  // ----------------------------------------------------------------
  // core stall
  // ----------------------------------------------------------------
  // core waits from the start of a non-page cycle until its count reaches zero, a clock before the strobe ends
  assign o_fetch_stall = bus_busy || (bus_start && need_stall);

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // strobes come from the registered cycle state, never from the live decode
  wire cyc_code  = bus_act_q && bus_code_q;
  wire cyc_read  = bus_act_q && !bus_code_q && !bus_wr_q;
  wire cyc_write = bus_act_q && !bus_code_q && bus_wr_q;

  assign o_code_fetch_strobe_n = !cyc_code;
  assign o_rd_n                = !cyc_read;
  assign o_wr_n                = !cyc_write;
  assign o_port_zero_addr      = bus_addr_q[7:0];
  assign o_port_two_addr       = bus_addr_q[15:8];
  assign o_bus_owns_ports      = bus_act_q;

  // ----------------------------------------------------------------
  // route outputs
  // ----------------------------------------------------------------
  assign o_fetch_route = '{addr: i_fetch_addr, src: fetch_src};
  assign o_data_route  = '{addr: xaddr,
                           src:  above_data_sram(xaddr) ? CDD_SRC_EXT : CDD_SRC_SRAM};

  // ----------------------------------------------------------------
  // scratchpad classification
  // ----------------------------------------------------------------
  wire scratch_high = (i_scratch_addr >= CDD_UPPER_RAM_LO);
  assign o_scratch_is_sfr   = scratch_high && !i_scratch_indirect;
  assign o_scratch_is_upper = scratch_high && i_scratch_indirect;
  // bit-addressable bytes only in the low window; sfr bit access is elsewhere
  assign o_scratch_bit_ok   = in_window({8'h00, i_scratch_addr},
                                        {8'h00, CDD_BIT_RAM_LO}, {8'h00, CDD_BIT_RAM_HI});

endmodule
`default_nettype wire

// File: src/cdd_pkg.sv
// package: constants and carriers for the code/data address decoder
package cdd_pkg;

  // ----------------------------------------------------------------
  // register layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CDD_SIZE_SEL_ADDR     = 8'hc2;
  localparam logic [7:0] CDD_TA_ADDR           = 8'hc7;
  localparam int         CDD_LIMIT_LSB         = 0;
  localparam int         CDD_LIMIT_W           = 3;
  localparam int         CDD_SRAM_CODE_BIT     = 3;
  localparam logic [7:0] CDD_SIZE_SEL_RST_16K  = 8'hf5;
  localparam logic [7:0] CDD_SIZE_SEL_RST_64K  = 8'hf7;
  localparam logic [7:0] CDD_SIZE_SEL_UPPER    = 8'hf0;
  localparam logic [2:0] CDD_LIMIT_0K          = 3'h0;

  // ----------------------------------------------------------------
  // memory map
  // ----------------------------------------------------------------
  localparam logic [15:0] CDD_SRAM_CODE_LO     = 16'h0400;
  localparam logic [15:0] CDD_SRAM_CODE_HI     = 16'h07ff;
  localparam logic [15:0] CDD_SRAM_DATA_MAX    = 16'h03ff;
  localparam logic [15:0] CDD_VECTOR_MAX       = 16'h007f;
  localparam logic [7:0]  CDD_UPPER_RAM_LO     = 8'h80;
  localparam logic [7:0]  CDD_BIT_RAM_LO       = 8'h20;
  localparam logic [7:0]  CDD_BIT_RAM_HI       = 8'h2f;
  localparam logic [7:0]  CDD_TA_KEY1          = 8'haa;
  localparam logic [7:0]  CDD_TA_KEY2          = 8'h55;
  localparam logic [2:0]  CDD_TA_WINDOW        = 3'h3;

  // ----------------------------------------------------------------
  // external bus timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  CDD_NONPAGE_STALLS   = 2'h3;

  typedef enum logic [1:0] {
    CDD_SRC_FLASH,
    CDD_SRC_SRAM,
    CDD_SRC_EXT
  } cdd_src_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        use_ptr;
    logic [2:0]  reg_sel;
  } cdd_xreq_t;

  typedef struct packed {
    logic [15:0] addr;
    cdd_src_t    src;
  } cdd_route_t;

endpackage

// File: src/cdd_limit_decode.sv
// leaf: combinational decode of the code limit field
`timescale 1ns/1ps
`default_nettype none
module cdd_limit_decode
  import cdd_pkg::*;
(
  input  wire logic [2:0]  i_code,
  output logic      [15:0] o_max_addr,
  output logic             o_none
);

  // ----------------------------------------------------------------
  // size code to highest on-chip address
  // ----------------------------------------------------------------
  // code n>0 gives 2^(n-1) kB, except 111 which is 64 kB
  assign o_none     = (i_code == CDD_LIMIT_0K);
  assign o_max_addr = (i_code == 3'h7) ? 16'hffff :
                      (i_code == 3'h0) ? 16'h0000 :
                      16'((17'h00400 << (i_code - 3'h1)) - 17'h00001);

endmodule
`default_nettype wire

// File: verification/cdd_top_assertions.sv
// checker: bus and decode relations seen at the decoder's ports
`timescale 1ns/1ps
`default_nettype none
module cdd_top_chk
  import cdd_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic        i_external_access_n,
  input wire logic [15:0] i_fetch_addr,
  input wire logic        o_fetch_stall,
  input wire cdd_route_t  o_fetch_route,
  input wire cdd_xreq_t   i_xreq,
  input wire logic [1:0]  i_bank_sel,
  input wire logic [4:0]  o_working_reg_addr,
  input wire cdd_route_t  o_data_route,
  input wire logic        i_page_mode1,
  input wire logic        i_page_hit,
  input wire logic [7:0]  i_scratch_addr,
  input wire logic        i_scratch_indirect,
  input wire logic        o_scratch_is_sfr,
  input wire logic        o_code_fetch_strobe_n,
  input wire logic        o_rd_n,
  input wire logic        o_wr_n,
  input wire logic [7:0]  o_port_zero_addr,
  input wire logic [7:0]  o_port_two_addr,
  input wire logic        o_bus_owns_ports
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  strobe_four_a: assert property ($fell(o_code_fetch_strobe_n) && !$past(i_page_mode1) |->
    !o_code_fetch_strobe_n [*4] ##1 o_code_fetch_strobe_n) else $error("code strobe length wrong");
  stall_window_a: assert property ($fell(o_code_fetch_strobe_n) && !$past(i_page_mode1) |->
    $past(o_fetch_stall) ##0 o_fetch_stall [*3] ##1 !o_fetch_stall) else $error("stall window wrong");
  page_hit_a: assert property ($fell(o_code_fetch_strobe_n) && $past(i_page_mode1) && $past(i_page_hit)
    |=> o_code_fetch_strobe_n) else $error("page hit strobe too long");
  fetch_no_data_a: assert property (!o_code_fetch_strobe_n |-> o_rd_n && o_wr_n)
    else $error("data strobe during code fetch");
  rd_wr_excl_a: assert property (o_rd_n || o_wr_n) else $error("read and write strobes together");
  pin_forces_ext_a: assert property (!i_external_access_n |-> o_fetch_route.src == CDD_SRC_EXT)
    else $error("fetch not external with pin low");
  bus_owns_a: assert property (!(o_code_fetch_strobe_n && o_rd_n && o_wr_n) |-> o_bus_owns_ports)
    else $error("ports not owned during bus cycle");
  fetch_addr_out_a: assert property ($fell(o_code_fetch_strobe_n) |->
    {o_port_two_addr, o_port_zero_addr} == $past(i_fetch_addr)) else $error("bus address wrong");
  data_split_a: assert property (i_xreq.valid |-> o_data_route.src ==
    ((o_data_route.addr > CDD_SRAM_DATA_MAX) ? CDD_SRC_EXT : CDD_SRC_SRAM)) else $error("data route wrong");
  reg_bank_a: assert property (o_working_reg_addr == {i_bank_sel, i_xreq.reg_sel})
    else $error("working register address wrong");
  scratch_sfr_a: assert property (o_scratch_is_sfr == (i_scratch_addr[7] && !i_scratch_indirect))
    else $error("scratch class wrong");
endmodule
bind cdd_top cdd_top_chk u_chk (.i_clock, .i_resetn, .i_external_access_n, .i_fetch_addr, .o_fetch_stall,
  .o_fetch_route, .i_xreq, .i_bank_sel, .o_working_reg_addr, .o_data_route, .i_page_mode1, .i_page_hit,
  .i_scratch_addr, .i_scratch_indirect, .o_scratch_is_sfr, .o_code_fetch_strobe_n, .o_rd_n, .o_wr_n,
  .o_port_zero_addr, .o_port_two_addr, .o_bus_owns_ports);
`default_nettype wire

// File: verification/cdd_ext_mem.sv
// partner: external program memory on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module cdd_ext_mem (
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic       i_code_fetch_strobe_n,
  output logic      [7:0] o_fetch_count
);
  logic strobe_q;
  // one count per output-enable window, so a strobe held for four clocks is one read
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      strobe_q      <= 1'b1;
      o_fetch_count <= 8'h00;
    end else begin
      strobe_q <= i_code_fetch_strobe_n;
      if (strobe_q && !i_code_fetch_strobe_n) o_fetch_count <= o_fetch_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: verification/code_data_address_decode_test.sv
// testbench: directed sequences for the code/data address decoder
`timescale 1ns/1ps
`default_nettype none
module code_data_address_decode_test;
  import cdd_pkg::*;
  logic clk, rstn, swr, ean, freq, psel, pm1, phit, sind, stall, fsn, rdn, wrn, own, isfr, iup, bok;
  logic [7:0]  sadr, swd, wrb, p2l, scad, rdat, p0a, p2a, nf;
  logic [15:0] fadr, dp0, dp1, lim;
  logic [1:0]  bank;
  logic [4:0]  wra;
  cdd_xreq_t   xq;
  cdd_route_t  fr, dr;
  int          bad_count, comparisons;
  logic [7:0]  sa [6] = '{8'h10, 8'h20, 8'h2f, 8'h30, 8'h80, 8'hff};
  cdd_top #(.LARGE_PART(1'b0)) dut (.i_clock(clk), .i_resetn(rstn), .i_sfr_wr(swr), .i_sfr_addr(sadr),
    .i_sfr_wdata(swd), .o_size_sel_rdata(rdat), .i_external_access_n(ean), .i_fetch_req(freq),
    .i_fetch_addr(fadr), .o_fetch_stall(stall), .o_fetch_route(fr), .i_xreq(xq), .i_bank_sel(bank),
    .i_working_reg_byte(wrb), .i_port_two_latch(p2l), .i_data_pointer0(dp0), .i_data_pointer1(dp1),
    .i_pointer_sel(psel), .o_working_reg_addr(wra), .o_data_route(dr), .i_page_mode1(pm1), .i_page_hit(phit),
    .i_scratch_addr(scad), .i_scratch_indirect(sind), .o_scratch_is_sfr(isfr), .o_scratch_is_upper(iup),
    .o_scratch_bit_ok(bok), .o_code_fetch_strobe_n(fsn), .o_rd_n(rdn), .o_wr_n(wrn),
    .o_port_zero_addr(p0a), .o_port_two_addr(p2a), .o_bus_owns_ports(own));
  cdd_ext_mem u_mem (.i_clock(clk), .i_resetn(rstn), .i_code_fetch_strobe_n(fsn), .o_fetch_count(nf));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    swr  <= 1'b1;
    sadr <= a;
    swd  <= d;
  endtask
  task automatic sw_end;
    @(posedge clk);
    swr <= 1'b0;
    @(negedge clk);
  endtask
  // limit only changed while no fetch is in flight
  task automatic set_size(input logic [7:0] v);
    sw(CDD_TA_ADDR, CDD_TA_KEY1);
    sw(CDD_TA_ADDR, CDD_TA_KEY2);
    sw(CDD_SIZE_SEL_ADDR, v);
    sw_end();
  endtask
  task automatic fetch_at(input logic [15:0] a, input cdd_src_t s);
    @(posedge clk);
    fadr <= a;
    @(negedge clk);
    chk("fetch route", fr, {a, s});
  endtask
  task automatic bus(input string what, input logic dat, input logic [2:0] act, input int n, input logic [15:0] ea);
    @(posedge clk);
    if (dat) xq.valid <= 1'b1;
    else freq <= 1'b1;
    @(negedge clk);
    if (!dat) chk({what, " stall"}, stall, n == 4);
    @(posedge clk);
    xq.valid <= 1'b0;
    freq     <= 1'b0;
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      chk(what, {fsn, rdn, wrn, own, p2a, p0a}, {act, 1'b1, ea});
    end
    @(negedge clk);
    chk({what, " end"}, {fsn, rdn, wrn}, 3'h7);
    $display("test %s done", what);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {swr, freq, psel, pm1, phit, sind, sadr, swd, wrb, p2l, scad, fadr, dp0, dp1, bank, xq} = '0;
    rstn = 1'b0;
    ean  = 1'b1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("size reset", rdat, CDD_SIZE_SEL_RST_16K);
    sw(CDD_SIZE_SEL_ADDR, 8'h0b);
    sw_end();
    chk("locked write", rdat, 8'hfd);
    for (int c = 0; c < 8; c++) begin
      set_size({5'h00, c[2:0]});
      lim = (c == 0) ? 16'h0000 : 16'((32'h400 << (c - 1)) - 1);
      chk("size code", rdat, {5'h1e, c[2:0]});
      chk("limit at once", fr.src, (c == 0) ? CDD_SRC_EXT : CDD_SRC_FLASH);
      fetch_at(lim, (c == 0) ? CDD_SRC_EXT : CDD_SRC_FLASH);
      if (c < 7) fetch_at(lim + 16'h0001, CDD_SRC_EXT);
    end
    $display("test size limits done");
    fetch_at(CDD_VECTOR_MAX, CDD_SRC_FLASH);
    @(posedge clk);
    ean <= 1'b0;
    fetch_at(16'h0000, CDD_SRC_EXT);
    @(posedge clk);
    ean <= 1'b1;
    set_size(8'h09);
    fetch_at(16'h0500, CDD_SRC_SRAM);
    fetch_at(16'h0800, CDD_SRC_EXT);
    fetch_at(16'h0010, CDD_SRC_FLASH);
    fetch_at(16'h1234, CDD_SRC_EXT);
    $display("test code map done");
    bus("ext fetch", 1'b0, 3'b011, 4, 16'h1234);
    chk("partner reads", nf, 8'h01);
    @(posedge clk);
    pm1  <= 1'b1;
    phit <= 1'b1;
    bus("page hit", 1'b0, 3'b011, 1, 16'h1234);
    @(posedge clk);
    {pm1, phit, bank, wrb, p2l} <= {2'b00, 2'h2, 8'h80, 8'h12};
    xq <= {1'b0, 1'b0, 1'b0, 3'h5};
    @(negedge clk);
    chk("reg addr", wra, 5'h15);
    chk("indirect route", dr, {16'h1280, CDD_SRC_EXT});
    bus("indirect read", 1'b1, 3'b101, 4, 16'h1280);
    @(posedge clk);
    {psel, dp0, dp1} <= {1'b1, 16'h0400, 16'h03ff};
    xq <= {1'b0, 1'b1, 1'b1, 3'h0};
    @(negedge clk);
    chk("pointer one route", dr, {16'h03ff, CDD_SRC_SRAM});
    @(posedge clk);
    psel <= 1'b0;
    @(negedge clk);
    chk("pointer zero route", dr, {16'h0400, CDD_SRC_EXT});
    bus("pointer write", 1'b1, 3'b110, 4, 16'h0400);
    foreach (sa[i]) for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      scad <= sa[i];
      sind <= m[0];
      @(negedge clk);
      chk("scratch class", {isfr, iup, bok}, {sa[i][7] & !m[0], sa[i][7] & m[0],
        sa[i] >= CDD_BIT_RAM_LO && sa[i] <= CDD_BIT_RAM_HI});
    end
    $display("test scratch done");
    results();
  end
endmodule
`default_nettype wire
